/* hw/pmr_consts.svh */
// register map, field positions, reset values and behaviour summary of the mode/set-point block
// Behaviour
// R1 - mode bit 7 selects sense amplifier gain: 0 gives 20 V/V, 1 gives 40 V/V.
// R2 - mode bit 6 enables input overcurrent detection; detection sets status D1 and fault pin.
// R3 - mode bit 4 selects boost: 0 current mode, 1 voltage mode.
// R4 - mode bit 3 forces variable rail into PWM; 0 allows automatic pulse skipping.
// R5 - mode bit 0 forces the overvoltage MOSFET off; 0 leaves protection circuit in charge.
// R6 - rail set point is a 6-bit code; 00h invalid, 01h first valid.
// R7 - first change of rail set point from 00h to nonzero sets lockout bit 7.
// R8 - once locked, rail set point writes are ignored until power cycle.
// R9 - rail set point register stays readable including the lockout flag.
// R10 - rail runs only when its enable is 1 and set point above 00h.
// R11 - rail faults reach the fault pin only while the rail is running.
// R12 - LED current set point is 6-bit, 1 mA per step; 00h invalid.
// R13 - host should change LED current by at most 16 mA per write.
// R14 - LED current set point has no lockout and accepts any rewrite.
// R15 - in current mode, reaching the boost voltage threshold latches boost off at once.
// R16 - host restarts boost after overvoltage by clear-faults then enable, or power cycle.
// R17 - boost overvoltage code 01h is 13.4 V, 300 mV steps; 00h invalid.
// R18 - boost voltage set point is programmable once in both modes, then locked.
// R19 - enable register holds per-converter enables; 1 enables, 0 disables.
// R20 - a converter turned off by a fault has its enable bit cleared.
// R21 - reserved and don't-care bits ignore writes and read as zero.
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH
`define PMR_ADDR_ENABLE    8'h07
`define PMR_ADDR_MODE      8'h09
`define PMR_ADDR_RAIL_SP   8'h0A
`define PMR_ADDR_LED_SP    8'h0B
`define PMR_ADDR_BOOST_SP  8'h0C
`define PMR_ADDR_FLT_STAT  8'h0D
`define PMR_SP_W           6
`define PMR_LOCK_BIT       7
`define PMR_MODE_GAIN      7
`define PMR_MODE_OCFLG     6
`define PMR_MODE_BSTMODE   4
`define PMR_MODE_FPWM      3
`define PMR_MODE_OVERVOLTAGE_SWITCH_OFF     0
`define PMR_EN_BOOST       4
`define PMR_EN_RAIL        3
`define PMR_FS_BSTFLT1     7
`define PMR_FS_BSTFLT0     6
`define PMR_FS_VOKFLT      5
`define PMR_FS_INPUT_OVERCURRENT_STATUS        1
`define PMR_MODE_MASK      8'hD9
`define PMR_EN_MASK        8'h18
`define PMR_RESET_BYTE     8'h00
`define PMR_SP_INVALID     6'h00
`endif

/* hw/pmr_pkg.sv */
// shared types of the mode/set-point block
package pmr_pkg;
  typedef logic [7:0] pmr_byte_t;
  typedef logic [5:0] pmr_code_t;
endpackage

/* hw/pmr_sp_if.sv */
// write and state signals of one lockable set-point register
`timescale 1ns/100ps
interface pmr_sp_if #(parameter int W = 6);
  logic         wr;
  logic [W-1:0] wdata;
  logic [W-1:0] code;
  logic         lock;
  modport ctrl (output wr, output wdata, input code, input lock);
  modport regs (input wr, input wdata, output code, output lock);
endinterface

/* hw/pmr_otp_setpoint.sv */
// one-time programmable set point with lockout flag
`timescale 1ns/100ps
`include "pmr_consts.svh"
module pmr_otp_setpoint #(
  parameter int W = 6
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  pmr_sp_if.regs    sp
);
  // writing 00h while unlocked leaves it open: only a valid code counts
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sp.code <= '0;
      sp.lock <= 1'b0;
    end else if (sp.wr && !sp.lock) begin // [R8] [R18]
      sp.code <= sp.wdata;
      if (sp.wdata != '0) begin
        sp.lock <= 1'b1; // [R7] [R18]
      end
    end
  end
endmodule // pmr_otp_setpoint

/* hw/pmr_mode_setpoint_regs.sv */
// mode, set-point, enable and fault-status registers of the power controller
`timescale 1ns/100ps
`include "pmr_consts.svh"
module pmr_mode_setpoint_regs #(
  parameter int SP_W = `PMR_SP_W
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output      logic [7:0]        reg_rdata,
  input  wire logic              clear_faults_command,
  input  wire logic              input_overcurrent_sensed,
  input  wire logic              boost_ov_reached,
  input  wire logic              variable_rail_fault,
  output      logic              sense_gain_select,
  output      logic              input_overcurrent_flag_enable,
  output      logic              boost_mode_select,
  output      logic              force_pwm_variable_rail,
  output      logic              overvoltage_switch_off,
  output      logic              variable_rail_on,
  output      logic [SP_W-1:0]   rail_voltage_code,
  output      logic              boost_converter_on,
  output      logic [SP_W-1:0]   led_current_code,
  output      logic [SP_W-1:0]   boost_voltage_code,
  output      logic              fault_pin_n
);
  pmr_sp_if #(.W(SP_W)) rail_sp ();
  pmr_sp_if #(.W(SP_W)) boost_sp ();

  pmr_pkg::pmr_byte_t mode_q;
  pmr_pkg::pmr_byte_t enable_q;
  pmr_pkg::pmr_byte_t fstat_q;
  pmr_pkg::pmr_code_t led_sp_q;
  logic               rail_run;
  logic               boost_run;
  logic               boost_ov_hit;
  logic               oc_hit;
  logic               rail_hit;
  logic               wr_mode;
  logic               wr_en;
  logic               wr_led;

  assign wr_mode = reg_wr && (reg_addr == `PMR_ADDR_MODE);
  assign wr_en   = reg_wr && (reg_addr == `PMR_ADDR_ENABLE);
  assign wr_led  = reg_wr && (reg_addr == `PMR_ADDR_LED_SP);

  assign rail_sp.wr     = reg_wr && (reg_addr == `PMR_ADDR_RAIL_SP);
  assign rail_sp.wdata  = reg_wdata[SP_W-1:0];
  assign boost_sp.wr    = reg_wr && (reg_addr == `PMR_ADDR_BOOST_SP);
  assign boost_sp.wdata = reg_wdata[SP_W-1:0];

  pmr_otp_setpoint #(.W(SP_W)) u_rail_sp (
    .clk_sys (clk_sys),
    .srst    (srst),
    .sp      (rail_sp)
  );

  pmr_otp_setpoint #(.W(SP_W)) u_boost_sp (
    .clk_sys (clk_sys),
    .srst    (srst),
    .sp      (boost_sp)
  );

  // run conditions: enable bit set and active set point valid
  assign rail_run = enable_q[`PMR_EN_RAIL] &&
                    (rail_sp.code != `PMR_SP_INVALID); // [R10] [R6]
  // current mode regulates to the LED current, voltage mode to the voltage set point
  assign boost_run = enable_q[`PMR_EN_BOOST] &&
                     (mode_q[`PMR_MODE_BSTMODE] ? (boost_sp.code != `PMR_SP_INVALID)
                                                 : (led_sp_q != `PMR_SP_INVALID)); // [R3] [R12]

  // fault events, each qualified by the state that makes it meaningful
  assign oc_hit       = input_overcurrent_sensed && mode_q[`PMR_MODE_OCFLG]; // [R2]
  assign rail_hit     = variable_rail_fault && rail_run; // [R11]
  assign boost_ov_hit = boost_ov_reached && boost_run &&
                        !mode_q[`PMR_MODE_BSTMODE] &&
                        (boost_sp.code != `PMR_SP_INVALID); // [R15] [R17]

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_q <= `PMR_RESET_BYTE;
    end else if (wr_mode) begin
      mode_q <= reg_wdata & `PMR_MODE_MASK; // [R21]
    end
  end

  // LED current freely rewritable, no lockout
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      led_sp_q <= `PMR_SP_INVALID;
    end else if (wr_led) begin
      led_sp_q <= reg_wdata[SP_W-1:0]; // [R14] [R12]
    end
  end

  // a fault clears its converter's enable; it beats a same-cycle host write
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enable_q <= `PMR_RESET_BYTE;
    end else begin
      if (wr_en) begin
        enable_q <= reg_wdata & `PMR_EN_MASK; // [R19] [R21]
      end
      if (rail_hit) begin
        enable_q[`PMR_EN_RAIL] <= 1'b0; // [R20]
      end
      if (boost_ov_hit) begin
        enable_q[`PMR_EN_BOOST] <= 1'b0; // [R15] [R20]
      end
    end
  end

  // status bits sticky; a new event wins over the clear command
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fstat_q <= `PMR_RESET_BYTE;
    end else begin
      if (clear_faults_command) begin
        fstat_q <= `PMR_RESET_BYTE; // [R16]
      end
      if (oc_hit) begin
        fstat_q[`PMR_FS_INPUT_OVERCURRENT_STATUS] <= 1'b1; // [R2]
      end
      if (rail_hit) begin
        fstat_q[`PMR_FS_VOKFLT] <= 1'b1; // [R11]
      end
      if (boost_ov_hit) begin
        fstat_q[`PMR_FS_BSTFLT1] <= 1'b0;
        fstat_q[`PMR_FS_BSTFLT0] <= 1'b1; // [R15]
      end
    end
  end

  // mode outputs and run flags, all registered
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sense_gain_select             <= 1'b0;
      input_overcurrent_flag_enable <= 1'b0;
      boost_mode_select             <= 1'b0;
      force_pwm_variable_rail       <= 1'b0;
      overvoltage_switch_off        <= 1'b0;
      variable_rail_on              <= 1'b0;
      boost_converter_on            <= 1'b0;
      rail_voltage_code             <= '0;
      led_current_code              <= '0;
      boost_voltage_code            <= '0;
    end else begin
      sense_gain_select             <= mode_q[`PMR_MODE_GAIN]; // [R1]
      input_overcurrent_flag_enable <= mode_q[`PMR_MODE_OCFLG]; // [R2]
      boost_mode_select             <= mode_q[`PMR_MODE_BSTMODE]; // [R3]
      force_pwm_variable_rail       <= mode_q[`PMR_MODE_FPWM]; // [R4]
      overvoltage_switch_off        <= mode_q[`PMR_MODE_OVERVOLTAGE_SWITCH_OFF]; // [R5]
      // boost drops the cycle the overvoltage is seen, not a cycle later
      variable_rail_on              <= rail_run && !rail_hit; // [R10]
      boost_converter_on            <= boost_run && !boost_ov_hit; // [R15]
      rail_voltage_code             <= rail_sp.code; // [R6]
      led_current_code              <= led_sp_q; // [R12]
      boost_voltage_code            <= boost_sp.code; // [R17]
    end
  end

  // pin low while any status bit stands or an event arrives this cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fault_pin_n <= 1'b1;
    end else begin
      fault_pin_n <= !((fstat_q != `PMR_RESET_BYTE) || oc_hit ||
                       rail_hit || boost_ov_hit); // [R2] [R11]
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= `PMR_RESET_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `PMR_ADDR_ENABLE:   reg_rdata <= enable_q;
        `PMR_ADDR_MODE:     reg_rdata <= mode_q;
        `PMR_ADDR_RAIL_SP:  reg_rdata <= {rail_sp.lock, 1'b0, rail_sp.code}; // [R9] [R21]
        `PMR_ADDR_LED_SP:   reg_rdata <= {2'b00, led_sp_q}; // [R21]
        `PMR_ADDR_BOOST_SP: reg_rdata <= {boost_sp.lock, 1'b0, boost_sp.code};
        `PMR_ADDR_FLT_STAT: reg_rdata <= fstat_q;
        default:            reg_rdata <= `PMR_RESET_BYTE;
      endcase
    end
  end
endmodule // pmr_mode_setpoint_regs

/* test/pmr_host_model.sv */
// host controller model issuing single-byte register strobes
`timescale 1ns/100ps
module pmr_host_model (
  input  logic       clk_sys,
  input  logic [7:0] reg_rdata,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       clear_faults_command
);
  initial begin
    {reg_wr, reg_rd, clear_faults_command} = 3'h0;
    {reg_addr, reg_wdata} = 16'h0000;
  end
  // released bus shows the inverse, so stale values never pass for live ones
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
  task automatic clear();
    @(posedge clk_sys);
    clear_faults_command <= 1'b1;
    @(posedge clk_sys);
    clear_faults_command <= 1'b0;
  endtask
  task automatic restart(input logic [7:0] en);
    clear();
    wr(8'h07, en);
  endtask
endmodule // pmr_host_model

/* test/pmr_mode_setpoint_regs_chk.sv */
// assertion checker on the ports of the mode/set-point register block
`timescale 1ns/100ps
module pmr_chk #(
  parameter int SP_W = 6
) (
  input logic            clk_sys,
  input logic            srst,
  input logic            reg_wr,
  input logic            reg_rd,
  input logic [7:0]      reg_addr,
  input logic [7:0]      reg_wdata,
  input logic [7:0]      reg_rdata,
  input logic            boost_ov_reached,
  input logic            input_overcurrent_sensed,
  input logic            variable_rail_fault,
  input logic            sense_gain_select,
  input logic            input_overcurrent_flag_enable,
  input logic            boost_mode_select,
  input logic            force_pwm_variable_rail,
  input logic            overvoltage_switch_off,
  input logic            variable_rail_on,
  input logic [SP_W-1:0] rail_voltage_code,
  input logic            boost_converter_on,
  input logic [SP_W-1:0] led_current_code,
  input logic [SP_W-1:0] boost_voltage_code,
  input logic            fault_pin_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [15:0] wd_q;
  wire         wr_mode = reg_wr && reg_addr == 8'h09;
  always_ff @(posedge clk_sys) wd_q <= {wd_q[7:0], reg_wdata};
  AST_MODE_FIELDS: assert property (wr_mode |-> ##2
    {sense_gain_select, input_overcurrent_flag_enable, boost_mode_select,
    force_pwm_variable_rail, overvoltage_switch_off} == {wd_q[15:14], wd_q[12:11], wd_q[8]})
    else $error("mode outputs differ from written byte");
  // enable output lags the mode bit a cycle: it shows the bit that qualified last cycle
  AST_OC_FAULT: assert property ($past(input_overcurrent_sensed) &&
    input_overcurrent_flag_enable |-> !fault_pin_n) else $error("overcurrent missed");
  AST_RAIL_LOCK: assert property (rail_voltage_code != 0 |=> $stable(rail_voltage_code))
    else $error("locked rail code changed");
  AST_BOOST_LOCK: assert property (boost_voltage_code != 0 |=> $stable(boost_voltage_code))
    else $error("locked boost code changed");
  AST_RAIL_OFF: assert property (rail_voltage_code == 0 |-> !variable_rail_on)
    else $error("rail on with zero code");
  // a host enable write on the previous edge may already have stopped the rail
  AST_RAIL_FLT: assert property (variable_rail_fault && variable_rail_on &&
    !$past(reg_wr && reg_addr == 8'h07) |=> !fault_pin_n && !variable_rail_on)
    else $error("rail fault not handled");
  AST_LED_REWRITE: assert property (reg_wr && reg_addr == 8'h0B |-> ##2
    led_current_code == wd_q[13:8]) else $error("led code not rewritten");
  AST_OV_LATCH: assert property (boost_ov_reached && boost_converter_on &&
    !boost_mode_select && boost_voltage_code != 0 |=> (!boost_converter_on && !fault_pin_n)[*2])
    else $error("boost not latched off");
  AST_RAIL_READ: assert property (reg_rd && reg_addr == 8'h0A |=>
    reg_rdata == {rail_voltage_code != 0, 1'b0, rail_voltage_code}) else $error("rail readback");
  AST_MODE_RSVD: assert property (reg_rd && reg_addr == 8'h09 |=> (reg_rdata & 8'h26) == 0)
    else $error("mode reserved bits set");
  cover property (wr_mode);
  cover property (boost_ov_reached && boost_converter_on);
  cover property ($rose(rail_voltage_code != 0));
endmodule // pmr_chk

/* test/pmr_mode_setpoint_regs_tb_top.sv */
// self-checking bench for the mode/set-point register block
`timescale 1ns/100ps
module pmr_mode_setpoint_regs_tb_top;
  logic       clk_sys, srst, reg_wr, reg_rd, clear_faults_command, fault_pin_n;
  logic       input_overcurrent_sensed, boost_ov_reached, variable_rail_fault;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       sense_gain_select, input_overcurrent_flag_enable, boost_mode_select;
  logic       force_pwm_variable_rail, overvoltage_switch_off, variable_rail_on;
  logic       boost_converter_on;
  logic [5:0] rail_voltage_code, led_current_code, boost_voltage_code;
  int         num_errors = 0;
  int         checks = 0;
  wire  [7:0] mode_out = {3'h0, sense_gain_select, input_overcurrent_flag_enable,
                          boost_mode_select, force_pwm_variable_rail, overvoltage_switch_off};
  pmr_mode_setpoint_regs i_dut (.clk_sys, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .clear_faults_command, .input_overcurrent_sensed, .boost_ov_reached,
    .variable_rail_fault, .sense_gain_select, .input_overcurrent_flag_enable, .boost_mode_select,
    .force_pwm_variable_rail, .overvoltage_switch_off, .variable_rail_on, .rail_voltage_code,
    .boost_converter_on, .led_current_code, .boost_voltage_code, .fault_pin_n);
  pmr_host_model u_host (.clk_sys, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .clear_faults_command);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // one-cycle event on {overcurrent, boost overvoltage, rail fault}
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_sys);
    {input_overcurrent_sensed, boost_ov_reached, variable_rail_fault} <= m;
    @(posedge clk_sys);
    {input_overcurrent_sensed, boost_ov_reached, variable_rail_fault} <= 3'b000;
    settle();
  endtask
  task automatic t_regs();
    logic [7:0] am [6] = '{8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
    foreach (am[i]) rdc(am[i], 8'h00);
    u_host.wr(8'h09, 8'hFF);
    u_host.wr(8'h0D, 8'hFF);
    settle();
    chk("mode out", mode_out, 8'h1F);
    rdc(8'h09, 8'hD9);
    rdc(8'h0D, 8'h00);
    rdc(8'h20, 8'h00);
    u_host.wr(8'h09, 8'h00);
    settle();
    chk("mode out", mode_out, 8'h00);
  endtask
  task automatic t_rail();
    u_host.wr(8'h0A, 8'h00);
    rdc(8'h0A, 8'h00);
    u_host.wr(8'h07, 8'h08);
    pulse(3'b001);
    chk("rail idle", {6'h00, fault_pin_n, variable_rail_on}, 8'h02);
    u_host.wr(8'h0A, 8'h45);
    rdc(8'h0A, 8'h85);
    u_host.wr(8'h0A, 8'h3F);
    rdc(8'h0A, 8'h85);
    chk("rail on", {7'h00, variable_rail_on}, 8'h01);
    pulse(3'b001);
    chk("rail fault", {6'h00, fault_pin_n, variable_rail_on}, 8'h00);
    rdc(8'h07, 8'h00);
    rdc(8'h0D, 8'h20);
    u_host.clear();
    rdc(8'h0D, 8'h00);
  endtask
  task automatic t_led();
    logic [7:0] v [5] = '{8'h10, 8'h20, 8'h30, 8'h3F, 8'hF0};
    // steps stay within 16 codes per write
    foreach (v[i]) begin
      u_host.wr(8'h0B, v[i]);
      rdc(8'h0B, v[i] & 8'h3F);
    end
  endtask
  task automatic t_oc();
    pulse(3'b100);
    rdc(8'h0D, 8'h00);
    u_host.wr(8'h09, 8'h40);
    settle();
    pulse(3'b100);
    rdc(8'h0D, 8'h02);
    chk("oc pin", {7'h00, fault_pin_n}, 8'h00);
    u_host.clear();
    u_host.wr(8'h09, 8'h00);
  endtask
  task automatic t_boost();
    u_host.wr(8'h0C, 8'h0A);
    u_host.wr(8'h0C, 8'h01);
    rdc(8'h0C, 8'h8A);
    u_host.wr(8'h07, 8'h10);
    settle();
    chk("boost on", {7'h00, boost_converter_on}, 8'h01);
    pulse(3'b010);
    chk("ov latch", {6'h00, boost_converter_on, fault_pin_n}, 8'h00);
    rdc(8'h0D, 8'h40);
    rdc(8'h07, 8'h00);
    u_host.restart(8'h10);
    settle();
    chk("restart", {6'h00, boost_converter_on, fault_pin_n}, 8'h03);
    u_host.wr(8'h09, 8'h10);
    pulse(3'b010);
    chk("volt mode", {6'h00, boost_converter_on, fault_pin_n}, 8'h03);
    @(posedge clk_sys);
    srst <= 1'b1;
    settle();
    @(posedge clk_sys);
    srst <= 1'b0;
    rdc(8'h0A, 8'h00);
    chk("after reset", {6'h00, boost_converter_on, fault_pin_n}, 8'h01);
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    {input_overcurrent_sensed, boost_ov_reached, variable_rail_fault} = 3'b000;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_rail();
    t_led();
    t_oc();
    t_boost();
    report_and_stop();
  end
  initial begin
    #20us;
    num_errors++;
    report_and_stop();
  end
endmodule // pmr_mode_setpoint_regs_tb_top
bind pmr_mode_setpoint_regs pmr_chk #(.SP_W(SP_W)) u_chk (.clk_sys, .srst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .boost_ov_reached, .input_overcurrent_sensed,
  .variable_rail_fault, .sense_gain_select, .input_overcurrent_flag_enable, .boost_mode_select,
  .force_pwm_variable_rail, .overvoltage_switch_off, .variable_rail_on, .rail_voltage_code,
  .boost_converter_on, .led_current_code, .boost_voltage_code, .fault_pin_n);
